// *** hdl/adc_sync_and_aux_control_regs.sv ***
// sync control and user auxiliary control registers with their effects
`timescale 1ns/1ps
`default_nettype none
module adc_sync_and_aux_control_regs
   import aux_ctrl_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire reg_req_t req_i,
   output logic [7:0] rdata_o,
   input wire logic sync_pin_i,
   input wire logic encode_clk_pin_i,
   input wire logic output_enable_bar_pin_i,
   output logic div_resync_o,
   output logic outputs_enabled_o,
   output logic low_rate_o,
   output logic low_rate_fallback_oscillator_run_o,
   output logic sdio_pulldown_en_o
);
   aux_state_t s_r;
   aux_state_t s_nxt;
   logic sync_rise;
   logic enc_rise;
   logic window_end;
   logic detect_en_nxt;

   // write strobe aimed at one register
   function automatic logic write_hit(input reg_req_t r, input logic [12:0] a);
      logic hit;
      hit = r.we && (r.addr == a);
      return hit;
   endfunction

   // shift a pin sample into its two-stage synchroniser
   function automatic logic [1:0] sync_shift(input logic [1:0] stages, input logic pin);
      logic [1:0] v;
      v = {stages[0], pin};
      return v;
   endfunction

   // rising edge of a synchronised pin against its delayed copy
   function automatic logic rise(input logic now, input logic prev);
      logic r;
      r = now & ~prev;
      return r;
   endfunction

   // reserved sync bits read back as zero
   function automatic logic [7:0] sync_mask(input logic [7:0] d);
      logic [7:0] m;
      m = {5'h00, d[2:0]};
      return m;
   endfunction

   // reserved aux bits read back as zero
   function automatic logic [7:0] aux_mask(input logic [7:0] d);
      logic [7:0] m;
      m = d & 8'h8D;
      return m;
   endfunction

   // both enables high before a pulse may reach the divider
   function automatic logic sync_armed(input logic [7:0] ctrl);
      logic armed;
      armed = ctrl[MASTER_SYNC_BIT] & ctrl[DIV_SYNC_EN_BIT];
      return armed;
   endfunction

   // one-shot sync mode selected
   function automatic logic one_shot(input logic [7:0] ctrl);
      logic os;
      os = ctrl[NEXT_SYNC_ONLY_BIT];
      return os;
   endfunction

   // too few encode edges in one window
   function automatic logic rate_low(input logic [3:0] cnt);
      logic low;
      low = (cnt < LOW_RATE_COUNT);
      return low;
   endfunction

   // read mux, unmapped addresses return zero
   function automatic logic [7:0] read_value(input logic [12:0] a, input logic [7:0] sc, input logic [7:0] ac);
      logic [7:0] v;
      unique case (a)
         SYNC_CONTROL_ADDR: v = sc;
         USER_AUX_CONTROL_ADDR: v = ac;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // pin high disables outputs only while the pin function is on
   function automatic logic oe_level(input logic [7:0] ac, input logic pin);
      logic en;
      en = ~(ac[OE_PIN_EN_BIT] & pin);
      return en;
   endfunction

   // forced run overrides the detector
   function automatic logic osc_run(input logic [7:0] ac, input logic low);
      logic run;
      run = ac[FORCE_OSC_BIT] | low;
      return run;
   endfunction

   always_comb begin
      s_nxt = s_r;
      sync_rise = rise(s_r.sync_pin_r[1], s_r.sync_prev_r);
      enc_rise = rise(s_r.enc_pin_r[1], s_r.enc_prev_r);
      window_end = (s_r.win_cnt_r == WINDOW_LAST);

      // two-stage pin synchronisers, one more stage for edges
      s_nxt.sync_pin_r = sync_shift(s_r.sync_pin_r, sync_pin_i);
      s_nxt.sync_prev_r = s_r.sync_pin_r[1];
      s_nxt.enc_pin_r = sync_shift(s_r.enc_pin_r, encode_clk_pin_i);
      s_nxt.enc_prev_r = s_r.enc_pin_r[1];
      s_nxt.oe_pin_r = sync_shift(s_r.oe_pin_r, output_enable_bar_pin_i);

      // register writes
      if (write_hit(req_i, SYNC_CONTROL_ADDR)) begin
         s_nxt.sync_control_r = sync_mask(req_i.wdata);
      end
      if (write_hit(req_i, USER_AUX_CONTROL_ADDR)) begin
         s_nxt.user_aux_control_r = aux_mask(req_i.wdata);
      end
      detect_en_nxt = s_nxt.user_aux_control_r[DETECT_EN_BIT];

      // sync gating; one-shot clear follows the write so it wins
      s_nxt.div_resync_r = 1'b0;
      if (sync_rise && sync_armed(s_r.sync_control_r)) begin
         s_nxt.div_resync_r = 1'b1;
         if (one_shot(s_r.sync_control_r)) begin
            s_nxt.sync_control_r[DIV_SYNC_EN_BIT] = 1'b0;
         end
      end

      // low encode rate detector: count encode edges per window
      if (window_end) begin
         s_nxt.win_cnt_r = 7'h00;
         s_nxt.edge_cnt_r = 4'h0;
         s_nxt.low_rate_r = detect_en_nxt && rate_low(s_r.edge_cnt_r);
      end else begin
         s_nxt.win_cnt_r = s_r.win_cnt_r + 7'h01;
         if (enc_rise && s_r.edge_cnt_r != 4'hF) begin
            s_nxt.edge_cnt_r = s_r.edge_cnt_r + 4'h1;
         end
      end
      // flag drops on the same edge that clears the detect bit
      if (!detect_en_nxt) begin
         s_nxt.low_rate_r = 1'b0;
      end

      // register reads
      if (req_i.re) begin
         s_nxt.rdata_r = read_value(req_i.addr, s_r.sync_control_r, s_r.user_aux_control_r);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s_r <= '0;
         s_r.sync_control_r <= SYNC_CONTROL_RST;
         s_r.user_aux_control_r <= USER_AUX_CONTROL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata_r;
   assign div_resync_o = s_r.div_resync_r;
   assign low_rate_o = s_r.low_rate_r;
   assign outputs_enabled_o = oe_level(s_r.user_aux_control_r, s_r.oe_pin_r[1]);
   assign low_rate_fallback_oscillator_run_o = osc_run(s_r.user_aux_control_r, s_r.low_rate_r);
   assign sdio_pulldown_en_o = ~s_r.user_aux_control_r[PULLDOWN_DIS_BIT];
endmodule
`default_nettype wire

// *** common/aux_ctrl_pkg.sv ***
// constants and carriers for the sync and auxiliary control registers
package aux_ctrl_pkg;
   localparam logic [12:0] SYNC_CONTROL_ADDR = 13'h0100;
   localparam logic [12:0] USER_AUX_CONTROL_ADDR = 13'h0101;
   localparam logic [7:0] SYNC_CONTROL_RST = 8'h01;
   localparam logic [7:0] USER_AUX_CONTROL_RST = 8'h88;
   localparam int MASTER_SYNC_BIT = 0;
   localparam int DIV_SYNC_EN_BIT = 1;
   localparam int NEXT_SYNC_ONLY_BIT = 2;
   localparam int PULLDOWN_DIS_BIT = 0;
   localparam int FORCE_OSC_BIT = 2;
   localparam int DETECT_EN_BIT = 3;
   localparam int OE_PIN_EN_BIT = 7;
   // low-rate threshold, in encode cycles per microsecond
   localparam int LOW_RATE_MSPS = 5;
   localparam int WINDOW_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;
   localparam logic [6:0] WINDOW_LAST = 7'(WINDOW_CYCLES - 1);
   localparam logic [3:0] LOW_RATE_COUNT = 4'(LOW_RATE_MSPS);

   typedef struct packed {
      logic we;
      logic re;
      logic [12:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] sync_control_r;
      logic [7:0] user_aux_control_r;
      logic [7:0] rdata_r;
      logic [1:0] sync_pin_r;
      logic sync_prev_r;
      logic [1:0] enc_pin_r;
      logic enc_prev_r;
      logic [6:0] win_cnt_r;
      logic [3:0] edge_cnt_r;
      logic low_rate_r;
      logic div_resync_r;
      logic [1:0] oe_pin_r;
   } aux_state_t;
endpackage

// *** testbench/aux_ctrl_properties.sv ***
// concurrent checks on the sync and auxiliary control ports
`timescale 1ns/1ps
`default_nettype none
module aux_ctrl_properties import aux_ctrl_pkg::*; (input wire logic clk_sys_i, input wire logic srst_i,
   input wire reg_req_t req_i, input wire logic div_resync_o, input wire logic outputs_enabled_o,
   input wire logic low_rate_o, input wire logic low_rate_fallback_oscillator_run_o, input wire logic sdio_pulldown_en_o);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   wire logic aw = req_i.we && req_i.addr == 13'h0101;
   wire logic sw = req_i.we && req_i.addr == 13'h0100;
   property p_pd; aw |=> sdio_pulldown_en_o == !$past(req_i.wdata[0]); endproperty
   a_pd: assert property (p_pd) else $error("pulldown");
   property p_frc; aw && req_i.wdata[2] |=> low_rate_fallback_oscillator_run_o; endproperty
   a_frc: assert property (p_frc) else $error("force");
   property p_doff; aw && !req_i.wdata[3] |=> !low_rate_o; endproperty
   a_doff: assert property (p_doff) else $error("detect off");
   property p_oe; aw && !req_i.wdata[7] |=> outputs_enabled_o; endproperty
   a_oe: assert property (p_oe) else $error("oe pin");
   property p_off; sw && req_i.wdata[1:0] != 2'h3 |-> ##2 !div_resync_o [*4]; endproperty
   a_off: assert property (p_off) else $error("sync gated");
   property p_run; low_rate_o |-> low_rate_fallback_oscillator_run_o; endproperty
   a_run: assert property (p_run) else $error("osc");
   property p_one; div_resync_o |=> !div_resync_o; endproperty
   a_one: assert property (p_one) else $error("pulse");
   property p_hold; $rose(low_rate_o) ##0 !aw [*8] |=> low_rate_o; endproperty
   a_hold: assert property (p_hold) else $error("low rate");
endmodule
bind adc_sync_and_aux_control_regs aux_ctrl_properties u_aux_ctrl_properties(.*);
`default_nettype wire

// *** testbench/spi_host_model.sv ***
// host side register access model
`timescale 1ns/1ps
`default_nettype none
module spi_host_model import aux_ctrl_pkg::*; (input wire logic clk_sys_i, output reg_req_t req_o,
   input wire logic [7:0] rdata_i);
   initial req_o = '0;
   task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys_i) req_o <= '{w, !w, a, d};
      @(posedge clk_sys_i) req_o <= '0;
      @(negedge clk_sys_i) q = rdata_i;
   endtask
endmodule
`default_nettype wire

// *** testbench/adc_sync_and_aux_control_regs_tb.sv ***
// bench for the sync and auxiliary control registers
`timescale 1ns/1ps
`default_nettype none
module adc_sync_and_aux_control_regs_tb;
   import aux_ctrl_pkg::*;
   logic clk_sys_i = 0, srst_i = 1, sync_pin_i = 0, encode_clk_pin_i = 0, output_enable_bar_pin_i = 0;
   reg_req_t req_i;
   logic [7:0] rdata_o, q;
   logic div_resync_o, outputs_enabled_o, low_rate_o, low_rate_fallback_oscillator_run_o, sdio_pulldown_en_o;
   int mismatches = 0, cmp_count = 0, pulses = 0, m[2] = '{8'h01, 8'h88};
   logic [7:0] sc[4] = '{8'h03, 8'h07, 8'h05, 8'h02};
   adc_sync_and_aux_control_regs u_adc_sync_and_aux_control_regs(.*);
   spi_host_model h(.clk_sys_i, .req_o(req_i), .rdata_i(rdata_o));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) pulses <= pulses + int'(div_resync_o);
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input int a, input logic [7:0] d);
      h.acc(1'b1, 13'(a), d, q);
      m[a - 256] = d & (a == 256 ? 8'h07 : 8'h8D);
   endtask
   task automatic rd(input int a);
      h.acc(1'b0, 13'(a), 8'h00, q);
      chk("rdata", q, 8'(m[a - 256]));
   endtask
   task automatic sync_case(input logic [7:0] d);
      int p0, e;
      wr(256, d);
      p0 = pulses;
      e = (m[0][1:0] == 2'h3) ? (m[0][2] ? 1 : 2) : 0;
      if (e == 1) m[0] = m[0] & 8'h05;
      repeat (2) begin
         @(posedge clk_sys_i) sync_pin_i <= 1;
         repeat (4) @(posedge clk_sys_i);
         sync_pin_i <= 0;
         repeat (8) @(posedge clk_sys_i);
      end
      chk("resync", 8'(pulses - p0), 8'(e));
      rd(256);
      $display("sync case %h done", d);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      conclude;
   end
   initial begin
      void'($urandom(45));
      repeat (8) @(posedge clk_sys_i);
      srst_i <= 0;
      rd(256);
      rd(257);
      foreach (sc[i]) sync_case(sc[i]);
      wr(257, 8'($urandom) | 8'h08);
      rd(257);
      chk("pulldown", 8'(sdio_pulldown_en_o), 8'(!m[1][0]));
      repeat (250) @(posedge clk_sys_i);
      @(negedge clk_sys_i) chk("lowrate", {low_rate_o, low_rate_fallback_oscillator_run_o}, 8'h03);
      wr(257, 8'h04);
      chk("force", {low_rate_o, low_rate_fallback_oscillator_run_o}, 8'h01);
      @(posedge clk_sys_i) output_enable_bar_pin_i <= 1;
      wr(257, 8'h81);
      repeat (3) @(negedge clk_sys_i);
      chk("oe", {outputs_enabled_o, low_rate_fallback_oscillator_run_o, sdio_pulldown_en_o}, 8'h00);
      wr(257, 8'h00);
      chk("oe off", 8'(outputs_enabled_o), 8'h01);
      $display("aux tests done");
      conclude;
   end
endmodule
`default_nettype wire
